// ===== rtl/flash_erase_select_ram_overlay.sv
`timescale 1ns/10ps
`include "flash_sel_defs.svh"
// Contract
// - eight bits select flash blocks 7..0 for erase, reset to zero
// - erase select writable only in modes 5 and 7, reads zero otherwise
// - mask-ROM variant reads all ones at both addresses, ignores writes
// - in mode 6 no erase select bit can be set
// - enable maps overlay RAM onto one of four 1 KB low windows
// - overlay control resets to f1, selection bits writable in modes 5 to 7
module flash_erase_select_ram_overlay #(
  parameter bit MASK_ROM = 1'b0
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic HSEL,
  input wire logic [11:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  output logic [7:0] ERASE_BLOCK_SEL,
  output logic OVERLAY_ACTIVE,
  output logic [23:0] OVERLAY_BASE
);
  flash_sel_pkg::bus_req_t req_q, req_d;
  logic [7:0] erase_block_select_reg_q, erase_block_select_reg_d;
  logic [7:0] overlay_control_reg_q, overlay_control_reg_d;
  logic [2:0] mode_q, mode_d;
  logic [7:0] erase_q, erase_d;
  logic act_q, act_d;
  logic [23:0] base_q, base_d;
  logic [31:0] rdata_d;
  logic rd_load;
  logic [31:0] rd_word;

  // register offsets are word indices; the byte address is four times the index
  function automatic logic [11:0] reg_addr(input logic [7:0] idx);
    reg_addr = {2'b00, idx, 2'b00};
  endfunction

  function automatic logic sel_writable(input logic [2:0] m);
    sel_writable = (m >= 3'h5);
  endfunction

  // hready low means another slave still stretches its data phase
  wire logic take = HSEL && HREADY && HTRANS[1];

  always_comb begin
    req_d = req_q;
    if (HREADY) begin
      req_d.sel = take;
      req_d.write = HWRITE;
      req_d.addr = HADDR;
    end
  end

  // registers: writes land in the data phase
  always_comb begin
    erase_block_select_reg_d = erase_block_select_reg_q;
    overlay_control_reg_d = overlay_control_reg_q;
    mode_d = mode_q;
    if (req_q.sel && req_q.write) begin
      // operating mode comes over the bus so that every mode can be reached
      if (req_q.addr == `MODE_REG_ADDR) begin
        mode_d = HWDATA[2:0];
      end else if (MASK_ROM) begin
        mode_d = mode_q;
      end else if (req_q.addr == reg_addr(`ERASE_SEL_IDX)) begin
        if (sel_writable(mode_q) && mode_q != 3'h6) begin
          erase_block_select_reg_d = HWDATA[7:0];
        end
      end else if (req_q.addr == reg_addr(`OVL_CTRL_IDX)) begin
        if (sel_writable(mode_q)) begin
          // reserved bits stay as reset
          overlay_control_reg_d = (HWDATA[7:0] & ~8'(`OVL_CTRL_RSVD_MASK)) | 8'(`OVL_CTRL_RSVD_MASK);
        end
      end
    end
    // mode 6 never holds a set erase bit, even if left over
    if (mode_d == 3'h6 || !sel_writable(mode_d)) begin
      erase_block_select_reg_d = `ERASE_SEL_RST;
    end
  end

  // next-state values, so a read right behind a write returns the new word
  always_comb begin
    rdata_d = 32'h00000000;
    rd_load = req_d.sel && !req_d.write;
    if (req_d.addr == `MODE_REG_ADDR) begin
      rdata_d = {29'h0, mode_d};
    end else if (req_d.addr == reg_addr(`ERASE_SEL_IDX)) begin
      rdata_d = MASK_ROM ? 32'h000000ff : {24'h0, erase_block_select_reg_d};
    end else if (req_d.addr == reg_addr(`OVL_CTRL_IDX)) begin
      rdata_d = MASK_ROM ? 32'h000000ff : {24'h0, overlay_control_reg_d};
    end
  end

  // overlay mapping
  always_comb begin
    erase_d = erase_block_select_reg_d;
    act_d = overlay_control_reg_d[`OVL_ENABLE_BIT] && !MASK_ROM;
    if (act_d) begin
      base_d = `OVL_EMU_BASE | (24'({overlay_control_reg_d[`OVL_BANK_HI_BIT],
        overlay_control_reg_d[`OVL_BANK_LO_BIT]}) << `OVL_WINDOW_SHIFT);
    end else begin
      base_d = `OVL_NORMAL_BASE;
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      req_q <= '0;
      erase_block_select_reg_q <= `ERASE_SEL_RST;
      overlay_control_reg_q <= `OVL_CTRL_RST;
      mode_q <= `MODE_RST;
      erase_q <= `ERASE_SEL_RST;
      act_q <= 1'b0;
      base_q <= `OVL_NORMAL_BASE;
    end else begin
      req_q <= req_d;
      erase_block_select_reg_q <= erase_block_select_reg_d;
      overlay_control_reg_q <= overlay_control_reg_d;
      mode_q <= mode_d;
      erase_q <= erase_d;
      act_q <= act_d;
      base_q <= base_d;
    end
  end

  flash_sel_wdata #(.WIDTH(32)) u_rdata (
    .clk(MCLK),
    .rst(RST),
    .load(rd_load),
    .din(rdata_d),
    .dout(rd_word)
  );

  // zero wait and always okay: no access needs a stretched data phase
  always_comb begin
    HRDATA = rd_word;
    HREADYOUT = 1'b1;
    HRESP = 1'b0;
    ERASE_BLOCK_SEL = erase_q;
    OVERLAY_ACTIVE = act_q;
    OVERLAY_BASE = base_q;
  end

  property p_mode6_clear;
    @(posedge MCLK) disable iff (RST) (mode_q == 3'h6) |=> (erase_block_select_reg_q == 8'h00);
  endproperty
  a_mode6_clear: assert property (p_mode6_clear) else $error("erase bits set in mode 6");
  property p_low_mode_clear;
    @(posedge MCLK) disable iff (RST) (mode_q < 3'h5) |=> (erase_block_select_reg_q == 8'h00);
  endproperty
  a_low_mode_clear: assert property (p_low_mode_clear) else $error("erase bits in low mode");
  property p_rsvd;
    @(posedge MCLK) disable iff (RST) (overlay_control_reg_q & 8'hf1) == 8'hf1;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved overlay bits changed");
  property p_map;
    @(posedge MCLK) disable iff (RST) overlay_control_reg_q[3] && !MASK_ROM |->
      OVERLAY_ACTIVE && OVERLAY_BASE == {12'h0, overlay_control_reg_q[2:1], 10'h0};
  endproperty
  a_map: assert property (p_map) else $error("overlay base wrong");
  property p_nomap;
    @(posedge MCLK) disable iff (RST) !overlay_control_reg_q[3] |-> OVERLAY_BASE == 24'hfff000 && !OVERLAY_ACTIVE;
  endproperty
  a_nomap: assert property (p_nomap) else $error("normal base wrong");
  property p_rom;
    @(posedge MCLK) disable iff (RST) MASK_ROM && req_d.sel && !req_d.write &&
      req_d.addr == 12'h108 |=> HRDATA == 32'h000000ff;
  endproperty
  a_rom: assert property (p_rom) else $error("mask rom read not ones");
  property p_ro_ovl;
    @(posedge MCLK) disable iff (RST) (mode_q < 3'h5) && (mode_d == mode_q) |=> $stable(overlay_control_reg_q);
  endproperty
  a_ro_ovl: assert property (p_ro_ovl) else $error("overlay written in read-only mode");
  property p_erase_out;
    @(posedge MCLK) disable iff (RST) ##1 ERASE_BLOCK_SEL == $past(erase_block_select_reg_d);
  endproperty
  a_erase_out: assert property (p_erase_out) else $error("erase output lags");

  // write effects are held against the bus data, not against the next-state logic
  property p_erase_write;
    @(posedge MCLK) disable iff (RST) !MASK_ROM && req_q.sel && req_q.write && req_q.addr == 12'h108 &&
      (mode_q == 3'h5 || mode_q == 3'h7) |=> erase_block_select_reg_q == $past(HWDATA[7:0]);
  endproperty
  a_erase_write: assert property (p_erase_write) else $error("erase select write lost");
  property p_ovl_write;
    @(posedge MCLK) disable iff (RST) !MASK_ROM && req_q.sel && req_q.write && req_q.addr == 12'h11c &&
      mode_q >= 3'h5 |=> overlay_control_reg_q == (($past(HWDATA[7:0]) & 8'h0e) | 8'hf1);
  endproperty
  a_ovl_write: assert property (p_ovl_write) else $error("overlay control write lost");
  property p_rom_ovl;
    @(posedge MCLK) disable iff (RST) MASK_ROM && req_d.sel && !req_d.write &&
      req_d.addr == 12'h11c |=> HRDATA == 32'h000000ff;
  endproperty
  a_rom_ovl: assert property (p_rom_ovl) else $error("mask rom overlay read not ones");
  property p_rom_frozen;
    @(posedge MCLK) disable iff (RST) MASK_ROM |->
      erase_block_select_reg_q == 8'h00 && overlay_control_reg_q == 8'hf1 && !OVERLAY_ACTIVE;
  endproperty
  a_rom_frozen: assert property (p_rom_frozen) else $error("mask rom register changed");
  property p_okay;
    @(posedge MCLK) disable iff (RST) HREADYOUT && !HRESP;
  endproperty
  a_okay: assert property (p_okay) else $error("bus answer not zero-wait okay");

  c_write_erase: cover property (@(posedge MCLK) erase_block_select_reg_q != 8'h00);
  c_map: cover property (@(posedge MCLK) OVERLAY_ACTIVE);
  c_mode6: cover property (@(posedge MCLK) mode_q == 3'h6 && req_q.sel && req_q.write);
  c_rom_read: cover property (@(posedge MCLK) MASK_ROM && req_q.sel && !req_q.write);
  c_top_window: cover property (@(posedge MCLK) OVERLAY_BASE == 24'h000c00);
endmodule

// ===== rtl/flash_sel_defs.svh
`ifndef FLASH_SEL_DEFS_SVH
`define FLASH_SEL_DEFS_SVH
`define ERASE_SEL_IDX 8'h42
`define OVL_CTRL_IDX 8'h47
`define MODE_REG_ADDR 12'h200
`define ERASE_SEL_RST 8'h00
`define OVL_CTRL_RST 8'hf1
`define OVL_CTRL_RSVD_MASK 8'hf1
`define OVL_ENABLE_BIT 3
`define OVL_BANK_HI_BIT 2
`define OVL_BANK_LO_BIT 1
`define OVL_NORMAL_BASE 24'hfff000
`define OVL_EMU_BASE 24'h000000
`define OVL_WINDOW_SHIFT 10
`define MODE_RST 3'h7
`endif

// ===== rtl/flash_sel_pkg.sv
package flash_sel_pkg;
  typedef struct packed {
    logic sel;
    logic write;
    logic [11:0] addr;
  } bus_req_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DATA = 2'b01
  } bus_state_t;
endpackage

// ===== rtl/flash_sel_wdata.sv
`timescale 1ns/10ps
// data-phase register: holds the word that the bus slave answers with
module flash_sel_wdata #(
  parameter int WIDTH = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] data_q;
  logic [WIDTH-1:0] data_d;
  always_comb begin
    data_d = load ? din : data_q;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_q <= '0;
    end else begin
      data_q <= data_d;
    end
  end
  assign dout = data_q;
endmodule

// ===== verif/tb_flash_erase_select_ram_overlay.sv
`timescale 1ns/10ps
`include "flash_sel_defs.svh"
module tb_flash_erase_select_ram_overlay;
  `define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin fail_count++; \
    $display("mismatch %s expected %h seen %h", n, e, a); end end
  typedef struct packed {logic [2:0] m; logic [11:0] a; logic [7:0] w; logic [7:0] r; logic [7:0] e;} row_t;
  localparam logic [11:0] EA = {2'b00, `ERASE_SEL_IDX, 2'b00};
  localparam logic [11:0] OA = {2'b00, `OVL_CTRL_IDX, 2'b00};
  localparam logic [11:0] MA = `MODE_REG_ADDR;
  logic MCLK, RST, HWRITE, HREADYOUT, OVERLAY_ACTIVE, hresp;
  logic [11:0] HADDR;
  logic [1:0] HTRANS;
  logic [31:0] HWDATA, HRDATA, rd2, rdv, rdm;
  logic [7:0] ERASE_BLOCK_SEL, eb2;
  logic [23:0] OVERLAY_BASE;
  int fail_count, n_tests;
  // mode walks through the rows in order, so each row inherits the last state
  row_t rows[9] = '{
    '{3'h7, EA, 8'ha5, 8'ha5, 8'ha5}, '{3'h7, OA, 8'h0e, 8'hff, 8'ha5},
    '{3'h5, EA, 8'h5a, 8'h5a, 8'h5a}, '{3'h6, EA, 8'hff, 8'h00, 8'h00},
    '{3'h6, OA, 8'h00, 8'hf1, 8'h00}, '{3'h4, EA, 8'hff, 8'h00, 8'h00},
    '{3'h7, OA, 8'h0a, 8'hfb, 8'h00}, '{3'h4, OA, 8'h00, 8'hfb, 8'h00},
    '{3'h7, OA, 8'hf0, 8'hf1, 8'h00}};
  flash_erase_select_ram_overlay flash_erase_select_ram_overlay_inst (.MCLK(MCLK), .RST(RST), .HSEL(1'b1),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(hresp), .ERASE_BLOCK_SEL(ERASE_BLOCK_SEL),
    .OVERLAY_ACTIVE(OVERLAY_ACTIVE), .OVERLAY_BASE(OVERLAY_BASE));
  // mask-ROM variant listens to the same bus; only its read data and its erase select output are observed
  flash_erase_select_ram_overlay #(.MASK_ROM(1'b1)) flash_erase_select_ram_overlay_inst_rom (.MCLK(MCLK),
    .RST(RST), .HSEL(1'b1), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA),
    .HREADY(HREADYOUT), .HRDATA(rd2), .HREADYOUT(), .HRESP(), .ERASE_BLOCK_SEL(eb2), .OVERLAY_ACTIVE(),
    .OVERLAY_BASE());
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge MCLK);
    HADDR <= a;
    HWRITE <= w;
    HTRANS <= 2'b10;
    do @(posedge MCLK); while (HREADYOUT !== 1'b1);
    HTRANS <= 2'b00;
    HWDATA <= w ? d : 32'h0;
    do @(posedge MCLK); while (HREADYOUT !== 1'b1);
    rdv = HRDATA;
    rdm = rd2;
    #1;
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    MCLK = 1'b0;
    forever #25 MCLK = ~MCLK;
  end
  initial begin
    #100000;
    fail_count++;
    end_sim;
  end
  initial begin
    RST = 1'b1;
    HADDR = 12'h0;
    HTRANS = 2'b00;
    HWRITE = 1'b0;
    HWDATA = 32'h0;
    repeat (4) @(posedge MCLK);
    RST <= 1'b0;
    #1;
    `CHK("erase sel reset", 8'h00, ERASE_BLOCK_SEL)
    `CHK("overlay base reset", `OVL_NORMAL_BASE, OVERLAY_BASE)
    xfer(1'b0, OA, 32'h0);
    `CHK("overlay reset read", 32'hf1, rdv)
    $display("test reset done");
    foreach (rows[i]) begin
      xfer(1'b1, MA, {29'h0, rows[i].m});
      xfer(1'b1, rows[i].a, {24'h0, rows[i].w});
      xfer(1'b0, rows[i].a, 32'h0);
      `CHK("register read", {24'h0, rows[i].r}, rdv)
      `CHK("erase sel out", rows[i].e, ERASE_BLOCK_SEL)
      $display("test row %0d done", i);
    end
    for (int b = 0; b < 5; b++) begin
      xfer(1'b1, OA, (b < 4) ? 32'(8 + 2 * b) : 32'h0);
      `CHK("overlay active", logic'(b < 4), OVERLAY_ACTIVE)
      `CHK("overlay base", (b < 4) ? 24'(b * 24'h400) : `OVL_NORMAL_BASE, OVERLAY_BASE)
    end
    $display("test overlay map done");
    xfer(1'b1, EA, 32'hff);
    xfer(1'b0, EA, 32'h0);
    `CHK("mask rom erase read", 32'hff, rdm)
    `CHK("erase sel all read", 32'hff, rdv)
    `CHK("erase sel all out", 8'hff, ERASE_BLOCK_SEL)
    `CHK("mask rom erase out", 8'h00, eb2)
    xfer(1'b0, OA, 32'h0);
    `CHK("mask rom overlay read", 32'hff, rdm)
    xfer(1'b0, 12'h004, 32'h0);
    `CHK("unmapped read", 32'h0, rdv)
    `CHK("response okay", 1'b0, hresp)
    $display("test mask rom and unmapped done");
    xfer(1'b1, MA, 32'h5);
    xfer(1'b1, OA, 32'h0e);
    `CHK("overlay top window", 24'h000c00, OVERLAY_BASE)
    @(posedge MCLK);
    RST <= 1'b1;
    repeat (2) @(posedge MCLK);
    RST <= 1'b0;
    #1;
    `CHK("erase sel mid reset", 8'h00, ERASE_BLOCK_SEL)
    `CHK("overlay active mid reset", 1'b0, OVERLAY_ACTIVE)
    `CHK("overlay base mid reset", `OVL_NORMAL_BASE, OVERLAY_BASE)
    xfer(1'b0, MA, 32'h0);
    `CHK("mode mid reset", 32'h7, rdv)
    xfer(1'b0, OA, 32'h0);
    `CHK("overlay mid reset read", 32'hf1, rdv)
    xfer(1'b1, EA, 32'h3c);
    `CHK("erase sel after reset", 8'h3c, ERASE_BLOCK_SEL)
    xfer(1'b1, EA, 32'h0);
    `CHK("erase sel cleared", 8'h00, ERASE_BLOCK_SEL)
    $display("test mid reset done");
    end_sim;
  end
endmodule
